/* File: testbench/sram_link_asserts.sv */
// checker: timing relations on the pins between controller and memory ends
// assumes one clock with synchronous active-high reset, placed beside the link
`timescale 1ns/100ps
module sram_link_asserts (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic sleep_request,
  input wire logic address_advance_n,
  input wire logic chip_select_primary_n,
  input wire logic chip_select_secondary_high,
  input wire logic chip_select_secondary_n,
  input wire logic writeStrobeN,
  input wire logic clockGateN,
  input wire logic dataToMemOe,
  input wire logic dataFromMemOe
);
  logic sel;
  logic rdGo;
  logic wrGo;
  // cycle starts as the memory should see them; gated edges never count
  assign sel  = !chip_select_primary_n && chip_select_secondary_high && !chip_select_secondary_n;
  assign rdGo = !address_advance_n && sel && writeStrobeN && !clockGateN;
  assign wrGo = !address_advance_n && sel && !writeStrobeN && !clockGateN;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_sleep_no_drive: assert property (sleep_request[*4] |-> !dataFromMemOe)
    else $error("memory drives data while asleep");
  a_read_data_next: assert property ((!sleep_request)[*4] ##0 rdGo |=> dataFromMemOe)
    else $error("read start without data one cycle later");
  a_write_no_output: assert property (wrGo |-> dataToMemOe ##1 !dataFromMemOe)
    else $error("write start with wrong bus direction");
  a_deselect_no_output: assert property (!address_advance_n && !sel |=> !dataFromMemOe)
    else $error("memory drives data when not selected");
  a_deselect_stays: assert property
    (!dataFromMemOe && address_advance_n && $past(address_advance_n) |=> !dataFromMemOe)
    else $error("continue deselect left deselected state");
  a_sleep_entry_idle: assert property ($rose(sleep_request) |-> !dataToMemOe && !dataFromMemOe)
    else $error("sleep raised with an access pending");
  a_wake_guard_gap: assert property ($fell(sleep_request) |-> (!(rdGo || wrGo))[*2])
    else $error("cycle start too soon after wake");
  a_wake_deselected: assert property ($fell(sleep_request) |-> (!dataFromMemOe)[*3])
    else $error("memory not deselected after wake");
endmodule

/* File: testbench/testbench.sv */
// testbench: controller and memory ends joined by the link, judged end to end
// assumes 25 MHz clk_sys; the bench drives only the controller user side
`timescale 1ns/100ps
module testbench;
  import sram_ctl_pkg::*;
  logic                 clk_sys;
  logic                 reset;
  logic                 sleepWanted;
  logic                 cmdReady;
  logic                 readValid;
  logic                 sleeping;
  cmd_e                 cmd;
  cycle_e               cycleState;
  logic [ADDR_BITS-1:0] cmdAddr;
  logic [DATA_BITS-1:0] cmdData;
  logic [DATA_BITS-1:0] readData;
  logic [LANES-1:0]     cmdLanesN;
  int                   n_fail;
  int                   n_checks;
  int                   cycles;
  sram_link_if link();
  sram_memory_end sram_memory_end_i (.clk_sys(clk_sys), .reset(reset), .link(link),
    .sleeping(sleeping), .cycleState(cycleState));
  sram_controller_end sram_controller_end_i (.clk_sys(clk_sys), .reset(reset), .link(link),
    .cmd(cmd), .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdLanesN(cmdLanesN),
    .sleepWanted(sleepWanted), .cmdReady(cmdReady), .readData(readData),
    .readValid(readValid));
  sram_link_asserts sram_link_asserts_i (.clk_sys(clk_sys), .reset(reset),
    .sleep_request(link.sleep_request), .address_advance_n(link.address_advance_n),
    .chip_select_primary_n(link.chip_select_primary_n),
    .chip_select_secondary_high(link.chip_select_secondary_high),
    .chip_select_secondary_n(link.chip_select_secondary_n), .writeStrobeN(link.writeStrobeN),
    .clockGateN(link.clockGateN), .dataToMemOe(link.dataToMemOe),
    .dataFromMemOe(link.dataFromMemOe));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [DATA_BITS-1:0] seen, input logic [DATA_BITS-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // hold the command until the controller says ready, drop it after the taking edge
  task automatic issue(input cmd_e c, input logic [ADDR_BITS-1:0] a,
                       input logic [DATA_BITS-1:0] d, input logic [LANES-1:0] l);
    int k;
    @(posedge clk_sys);
    cmd <= c;
    cmdAddr <= a;
    cmdData <= d;
    cmdLanesN <= l;
    k = 0;
    @(negedge clk_sys);
    while (cmdReady !== 1'b1 && k < 40) begin
      @(negedge clk_sys);
      k++;
    end
    check(k < 40, 1'b1);
    @(posedge clk_sys);
    cmd <= CMD_NONE;
  endtask
  task automatic read_exp(input logic [ADDR_BITS-1:0] a, input logic [DATA_BITS-1:0] e);
    int k;
    issue(CMD_READ, a, 36'h0, LANES_OFF);
    k = 0;
    @(negedge clk_sys);
    while (readValid !== 1'b1 && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    check(readData, e);
  endtask
  task automatic wait_sleep(input logic v, input int lim);
    int k;
    k = 0;
    @(negedge clk_sys);
    while (sleeping !== v && k < lim) begin
      @(negedge clk_sys);
      k++;
    end
    check(sleeping, v);
  endtask
  // back-to-back writes, read back in reverse order
  task automatic t_write_read();
    issue(CMD_WRITE, 20'h00001, 36'h123456789, 4'h0);
    issue(CMD_WRITE, 20'h00002, 36'hfedcba987, 4'h0);
    read_exp(20'h00002, 36'hfedcba987);
    read_exp(20'h00001, 36'h123456789);
  endtask
  // one lane at a time over a cleared word, then a write with every lane off
  task automatic t_lanes();
    logic [DATA_BITS-1:0] e;
    e = 36'h0;
    issue(CMD_WRITE, 20'h00005, 36'h0, 4'h0);
    for (int i = 0; i < LANES; i++) begin
      issue(CMD_WRITE, 20'h00005, 36'hfffffffff, ~(4'h1 << i));
      e[i*LANE_BITS +: LANE_BITS] = 9'h1ff;
      read_exp(20'h00005, e);
    end
    issue(CMD_WRITE, 20'h00005, 36'h0, LANES_OFF);
    read_exp(20'h00005, e);
  endtask
  // sleep entry bound, long stay, refusal, then a clean wake
  task automatic t_sleep();
    issue(CMD_WRITE, 20'h00003, 36'h0a5a5a5a5, 4'h0);
    @(posedge clk_sys);
    sleepWanted <= 1'b1;
    wait_sleep(1'b1, 3);
    repeat (10) @(negedge clk_sys);
    check(sleeping, 1'b1);
    check(cmdReady, 1'b0);
    @(posedge clk_sys);
    sleepWanted <= 1'b0;
    wait_sleep(1'b0, 5);
    check(cycleState, CYC_IDLE);
    read_exp(20'h00003, 36'h0a5a5a5a5);
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // the scenarios need well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      wrap_up();
    end
  end
  initial begin
    reset = 1'b1;
    sleepWanted = 1'b0;
    cmd = CMD_NONE;
    cmdAddr = 20'h0;
    cmdData = 36'h0;
    cmdLanesN = LANES_OFF;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_write_read();
    t_lanes();
    t_sleep();
    wrap_up();
  end
endmodule

/* File: verilog/sram_controller_end.sv */
// controller end: turns user commands into sram pin activity and sleep requests
// assumes the memory end shares clk_sys; one command at a time
`timescale 1ns/100ps
module sram_controller_end
  import sram_ctl_pkg::*;
(
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  sram_link_if.controller           link,
  input  wire sram_ctl_pkg::cmd_e   cmd,
  input  wire logic [ADDR_BITS-1:0] cmdAddr,
  input  wire logic [DATA_BITS-1:0] cmdData,
  input  wire logic [LANES-1:0]     cmdLanesN,
  input  wire logic                 sleepWanted,
  output logic                      cmdReady,
  output logic [DATA_BITS-1:0]      readData,
  output logic                      readValid
);
  import sram_ctl_pkg::*;

  typedef struct packed {
    logic                 sleepPin;
    logic [1:0]           guardCnt;
    logic                 advN;
    logic                 selN;
    logic                 weN;
    logic [LANES-1:0]     lanesN;
    logic [ADDR_BITS-1:0] addr;
    logic [DATA_BITS-1:0] wdata;
    logic                 wdataOe;
    logic [1:0]           readPipe;
    logic [DATA_BITS-1:0] rdata;
    logic                 rvalid;
  } state_s;

  state_s cur;
  state_s next_cur;
  logic   idle;

  // commands only when quiet; sleep only once pipe drained
  always_comb begin
    next_cur = cur;
    idle = !cur.sleepPin && cur.guardCnt == 2'h0 && cur.readPipe == 2'h0;
    next_cur.advN    = 1'b0;
    next_cur.selN    = 1'b1;
    next_cur.weN     = 1'b1;
    next_cur.lanesN  = LANES_OFF;
    next_cur.wdataOe = 1'b0;
    next_cur.rvalid  = 1'b0;
    next_cur.readPipe = {cur.readPipe[0], 1'b0};
    if (cur.readPipe[1]) begin
      next_cur.rdata  = link.dataFromMem;
      next_cur.rvalid = 1'b1;
    end
    if (cur.guardCnt != 2'h0) begin
      next_cur.guardCnt = cur.guardCnt - 2'h1;
    end
    if (cur.sleepPin && !sleepWanted) begin
      next_cur.sleepPin = 1'b0;
      next_cur.guardCnt = SLEEP_EXIT_CNT;
    end else if (idle && sleepWanted && cmd == CMD_NONE) begin
      next_cur.sleepPin = 1'b1;
    end else if (idle && cmd != CMD_NONE) begin
      // start edge carries valid selects and a stable address
      next_cur.selN = 1'b0;
      next_cur.addr = cmdAddr;
      case (cmd)
        CMD_WRITE: begin
          next_cur.weN     = 1'b0;
          next_cur.lanesN  = cmdLanesN;
          next_cur.wdata   = cmdData;
          next_cur.wdataOe = 1'b1;
        end
        CMD_READ: next_cur.readPipe = 2'h1;
        default:  next_cur.advN = 1'b1;
      endcase
    end
    if (reset) begin
      next_cur = '0;
      next_cur.selN   = 1'b1;
      next_cur.weN    = 1'b1;
      next_cur.lanesN = LANES_OFF;
    end
  end

  // all pin levels except the tied-low clockGateN come from flip-flops
  always_ff @(posedge clk_sys) begin
    cur <= next_cur;
  end

  assign link.sleep_request              = cur.sleepPin;
  assign link.address_advance_n          = cur.advN;
  assign link.chip_select_primary_n      = cur.selN;
  assign link.chip_select_secondary_high = !cur.selN;
  assign link.chip_select_secondary_n    = cur.selN;
  assign link.writeStrobeN               = cur.weN;
  assign link.byte_lane_write_n          = cur.lanesN;
  assign link.clockGateN                 = 1'b0;
  assign link.address                    = cur.addr;
  assign link.dataToMem                  = cur.wdata;
  assign link.dataToMemOe                = cur.wdataOe;
  assign cmdReady                        = idle && !sleepWanted;
  assign readData                        = cur.rdata;
  assign readValid                       = cur.rvalid;
endmodule

/* File: verilog/sram_ctl_pkg.sv */
// shared constants and types for the sram cycle qualify and sleep control pair
// assumes a single 25 MHz clock shared by controller and memory ends
package sram_ctl_pkg;
  localparam int LANES          = 4;
  localparam int LANE_BITS      = 9;
  localparam int DATA_BITS      = LANES * LANE_BITS;
  localparam int ADDR_BITS      = 20;
  localparam int DEPTH_WORDS    = 16;
  localparam int MEM_ADDR_BITS  = 4;
  // sleep entry and exit are both two clock periods
  localparam int SLEEP_ENTER_CYC = 2;
  localparam int SLEEP_EXIT_CYC  = 2;
  localparam logic [1:0] SLEEP_ENTER_CNT = 2'h2;
  localparam logic [1:0] SLEEP_EXIT_CNT  = 2'h2;
  localparam logic [LANES-1:0] LANES_OFF = 4'hf;

  typedef enum logic [1:0] {CYC_IDLE, CYC_READ, CYC_WRITE} cycle_e;
  typedef enum logic [1:0] {CMD_NONE, CMD_READ, CMD_WRITE, CMD_BURST} cmd_e;

  // selection is active only when all three chip selects agree
  function automatic logic chip_selected(input logic primaryN,
                                         input logic secondaryHigh,
                                         input logic secondaryN);
    chip_selected = !primaryN && secondaryHigh && !secondaryN;
  endfunction

  // merge byte lanes that are enabled (active low) into an old word
  function automatic logic [DATA_BITS-1:0] lane_merge(input logic [DATA_BITS-1:0] oldWord,
                                                      input logic [DATA_BITS-1:0] newWord,
                                                      input logic [LANES-1:0]     laneN);
    logic [DATA_BITS-1:0] res;
    res = oldWord;
    for (int i = 0; i < LANES; i++) begin
      if (!laneN[i]) begin
        res[i*LANE_BITS +: LANE_BITS] = newWord[i*LANE_BITS +: LANE_BITS];
      end
    end
    lane_merge = res;
  endfunction
endpackage

/* File: verilog/sram_link_if.sv */
// pin bundle between a memory controller and the sram control end
// assumes both ends on the same clock; the data bus is split into dataToMem and dataFromMem, each with its own enable
`timescale 1ns/100ps
interface sram_link_if;
  import sram_ctl_pkg::*;
  logic                        sleep_request;
  logic                        address_advance_n;
  logic                        chip_select_primary_n;
  logic                        chip_select_secondary_high;
  logic                        chip_select_secondary_n;
  logic                        writeStrobeN;
  logic [LANES-1:0]            byte_lane_write_n;
  logic                        clockGateN;
  logic [ADDR_BITS-1:0]        address;
  logic [DATA_BITS-1:0]        dataToMem;
  logic                        dataToMemOe;
  logic [DATA_BITS-1:0]        dataFromMem;
  logic                        dataFromMemOe;

  modport memory (
    input  sleep_request, address_advance_n, chip_select_primary_n,
    input  chip_select_secondary_high, chip_select_secondary_n, writeStrobeN,
    input  byte_lane_write_n, clockGateN, address, dataToMem, dataToMemOe,
    output dataFromMem, dataFromMemOe
  );
  modport controller (
    output sleep_request, address_advance_n, chip_select_primary_n,
    output chip_select_secondary_high, chip_select_secondary_n, writeStrobeN,
    output byte_lane_write_n, clockGateN, address, dataToMem, dataToMemOe,
    input  dataFromMem, dataFromMemOe
  );
endinterface

/* File: verilog/sram_memory_end.sv */
// memory end: cycle qualification, burst continue, byte lanes and sleep gating
// assumes controller inputs synchronous to clk_sys; the sleep pin is sampled here
`timescale 1ns/100ps
module sram_memory_end
  import sram_ctl_pkg::*;
(
  input  wire logic          clk_sys,
  input  wire logic          reset,
  sram_link_if.memory        link,
  output logic               sleeping,
  output sram_ctl_pkg::cycle_e cycleState
);
  import sram_ctl_pkg::*;

  typedef struct packed {
    logic                     asleep;
    cycle_e                   cycle;
    logic [MEM_ADDR_BITS-1:0] addr;
    logic                     drive;
    logic [DATA_BITS-1:0]     rdata;
  } state_s;

  state_s                     cur;
  state_s                     next_cur;
  logic [DATA_BITS-1:0]       mem [DEPTH_WORDS];
  logic                       selected;
  logic                       start;
  logic                       active;
  logic                       doWrite;
  logic [MEM_ADDR_BITS-1:0]   accAddr;

  // the sleep pin gates inputs at once; after it drops, one edge clears the
  // sleep flag and the next edge samples again, inside the two-period wake guard
  always_comb begin
    next_cur = cur;
    selected = chip_selected(link.chip_select_primary_n, link.chip_select_secondary_high,
                             link.chip_select_secondary_n);
    active   = !cur.asleep && !link.sleep_request && !link.clockGateN;
    start    = active && !link.address_advance_n;
    doWrite  = 1'b0;
    accAddr  = cur.addr;
    next_cur.asleep = link.sleep_request;
    if (link.sleep_request || cur.asleep) begin
      next_cur.cycle = CYC_IDLE;
      next_cur.drive = 1'b0;
    end else if (start) begin
      if (!selected) begin
        next_cur.cycle = CYC_IDLE;
        next_cur.drive = 1'b0;
      end else begin
        accAddr = link.address[MEM_ADDR_BITS-1:0];
        next_cur.addr = accAddr + 1'b1;
        if (!link.writeStrobeN) begin
          next_cur.cycle = CYC_WRITE;
          doWrite = 1'b1;
          next_cur.drive = 1'b0;
        end else begin
          next_cur.cycle = CYC_READ;
          next_cur.drive = 1'b1;
          next_cur.rdata = mem[accAddr];
        end
      end
    end else if (active) begin
      // advance high: keep going on the next address, or stay deselected
      case (cur.cycle)
        CYC_READ: begin
          next_cur.rdata = mem[cur.addr];
          next_cur.addr  = cur.addr + 1'b1;
          next_cur.drive = 1'b1;
        end
        CYC_WRITE: begin
          doWrite = 1'b1;
          next_cur.addr = cur.addr + 1'b1;
        end
        default: next_cur.drive = 1'b0;
      endcase
    end
    if (reset) begin
      next_cur = '0;
      next_cur.cycle = CYC_IDLE;
      doWrite = 1'b0;
    end
  end

  // write data is applied to the addressed word in the same edge it is taken
  always_ff @(posedge clk_sys) begin
    cur <= next_cur;
    if (doWrite && link.byte_lane_write_n != LANES_OFF) begin
      mem[accAddr] <= lane_merge(mem[accAddr], link.dataToMem, link.byte_lane_write_n);
    end
  end

  assign link.dataFromMem   = cur.rdata;
  assign link.dataFromMemOe = cur.drive;
  assign sleeping           = cur.asleep;
  assign cycleState         = cur.cycle;
endmodule
